// File: src/timer2_pkg.sv
// Package for the capture/reload/baud timer: register map, field positions, resets, timing.
// Assumes an SFR-style byte bus with write/read strobes on the same clock.
package timer2_pkg;

  // ----------------------------------------
  // Register offsets in SFR space
  // ----------------------------------------
  localparam logic [7:0] timer_control_off = 8'hc8;
  localparam logic [7:0] timer_output_mode_off = 8'hc9;
  localparam logic [7:0] reload_low_off = 8'hca;
  localparam logic [7:0] reload_high_off = 8'hcb;
  localparam logic [7:0] count_low_off = 8'hcc;
  localparam logic [7:0] count_high_off = 8'hcd;
  localparam logic [7:0] clock_speed_off = 8'h8e;
  localparam logic [7:0] port_option_off = 8'hd0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int overflow_flag_bit = 7;
  localparam int external_flag_bit = 6;
  localparam int rx_clock_select_bit = 5;
  localparam int tx_clock_select_bit = 4;
  localparam int ext_trigger_enable_bit = 3;
  localparam int run_control_bit = 2;
  localparam int timer_counter_select_bit = 1;
  localparam int capture_reload_select_bit = 0;
  localparam int ovf_out_enable_bit = 1;
  localparam int speed_select_bit = 5;
  localparam int pin_alt_output_enable_bit = 0;

  // ----------------------------------------
  // Reset values and the count wrap point
  // ----------------------------------------
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [15:0] word_reset = 16'h0000;
  localparam logic [15:0] count_wrap = 16'hffff;

  // ----------------------------------------
  // Timing counts: crystal clocks per step, and the overflow count for the bit clock
  // ----------------------------------------
  localparam logic [3:0] fast_divide = 4'h4;
  localparam logic [3:0] slow_divide = 4'hc;
  localparam logic [3:0] baud_divide = 4'h2;
  localparam logic [3:0] baud_overflow_divide = 4'hf;

  // Bus request from the CPU side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// File: src/pin_edge_sync.sv
// Three-stage synchroniser with falling-edge detect for an external pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
module pin_edge_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic fall
);
  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic fall;
  } edge_state_t;

  edge_state_t state_reg;
  edge_state_t state_next;

  // Stage 0 is only read by stage 1; a change counts once stages 1 and 2 agree
  always_comb
  begin
    state_next = state_reg;
    state_next.sync = {state_reg.sync[1:0], pin};
    state_next.fall = 1'b0;
    if (state_reg.sync[1] == state_reg.sync[2] && state_reg.sync[2] != state_reg.level)
    begin
      state_next.level = state_reg.sync[2];
      state_next.fall = state_reg.level & ~state_reg.sync[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= '{sync: 3'h7, level: 1'b1, fall: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign fall = state_reg.fall;
endmodule // pin_edge_sync

// File: src/baud_divider.sv
// Divide-by-16 of timer overflow pulses into the UART bit clock.
// Assumes overflow pulses are one clk cycle wide.
`timescale 1ns/10ps
module baud_divider (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic overflow,
  output logic bit_clock
);
  typedef struct packed {
    logic [3:0] count;
    logic tick;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!enable)
    begin
      state_next.count = 4'h0;
    end
    else if (overflow)
    begin
      state_next.count = state_reg.count + 4'h1;
      state_next.tick = (state_reg.count == timer2_pkg::baud_overflow_divide);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign bit_clock = state_reg.tick;
endmodule // baud_divider

// File: src/timer2_capture_reload_baudgen.sv
// Sixteen-bit timer/counter with capture, auto-reload and UART baud generation.
// Assumes a byte SFR bus on clk (the crystal clock) and asynchronous trigger and count pins.
`timescale 1ns/10ps
module timer2_capture_reload_baudgen (
  input wire logic clk,
  input wire logic reset,
  input timer2_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic trigger_pin,
  input wire logic count_pin,
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe,
  output logic tx_bit_clock,
  output logic rx_bit_clock,
  output logic timer_irq_request
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] control;
    logic ovf_out_enable;
    logic speed_select;
    logic pin_alt_output_enable;
    logic [15:0] count;
    logic [15:0] reload;
    logic [3:0] prescale;
    logic [7:0] rdata;
    logic hit;
    logic pin_out;
    logic pin_oe;
    logic irq;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  logic trigger_fall;
  logic count_fall;
  logic tx_tick;
  logic rx_tick;
  logic baud_mode;
  logic [3:0] divide;
  logic step;
  logic wrap;
  logic hw_overflow_set;
  logic hw_external_set;
  logic do_reload;
  logic do_capture;
  logic [7:0] wbyte;

  // Reads are decoded in one place and reused for hit and data
  function automatic logic [8:0] read_decode(input timer_state_t s, input logic [7:0] addr);
    logic [8:0] r;
    r = 9'h000;
    unique case (addr)
      timer2_pkg::timer_control_off: r = {1'b1, s.control};
      timer2_pkg::timer_output_mode_off:
        r = {1'b1, 6'h00, s.ovf_out_enable, 1'b0};
      timer2_pkg::reload_low_off: r = {1'b1, s.reload[7:0]};
      timer2_pkg::reload_high_off: r = {1'b1, s.reload[15:8]};
      timer2_pkg::count_low_off: r = {1'b1, s.count[7:0]};
      timer2_pkg::count_high_off: r = {1'b1, s.count[15:8]};
      timer2_pkg::clock_speed_off: r = {1'b1, 2'h0, s.speed_select, 5'h00};
      timer2_pkg::port_option_off: r = {1'b1, 7'h00, s.pin_alt_output_enable};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_edge_sync trigger_sync (
    .clk(clk),
    .reset(reset),
    .pin(trigger_pin),
    .fall(trigger_fall)
  );

  pin_edge_sync count_sync (
    .clk(clk),
    .reset(reset),
    .pin(count_pin),
    .fall(count_fall)
  );

  // ----------------------------------------
  // UART bit clocks
  // ----------------------------------------
  baud_divider tx_div (
    .clk(clk),
    .reset(reset),
    .enable(state_reg.control[timer2_pkg::tx_clock_select_bit]),
    .overflow(wrap),
    .bit_clock(tx_tick)
  );

  baud_divider rx_div (
    .clk(clk),
    .reset(reset),
    .enable(state_reg.control[timer2_pkg::rx_clock_select_bit]),
    .overflow(wrap),
    .bit_clock(rx_tick)
  );

  // ----------------------------------------
  // Count engine
  // ----------------------------------------
  always_comb
  begin
    baud_mode = state_reg.control[timer2_pkg::tx_clock_select_bit]
      | state_reg.control[timer2_pkg::rx_clock_select_bit];
    if (baud_mode)
    begin
      divide = timer2_pkg::baud_divide;
    end
    else if (state_reg.speed_select)
    begin
      divide = timer2_pkg::fast_divide;
    end
    else
    begin
      divide = timer2_pkg::slow_divide;
    end
    // External pulses count even in baud mode; the half-rate rule covers the timer function
    if (state_reg.control[timer2_pkg::timer_counter_select_bit])
    begin
      step = state_reg.control[timer2_pkg::run_control_bit] & count_fall;
    end
    else
    begin
      step = state_reg.control[timer2_pkg::run_control_bit]
        & (state_reg.prescale == divide - 4'h1);
    end
    // Wrap rides on the step itself, so a stopped timer can never overflow
    wrap = step & (state_reg.count == timer2_pkg::count_wrap);
    hw_overflow_set = wrap & ~baud_mode;
    hw_external_set = trigger_fall & state_reg.control[timer2_pkg::ext_trigger_enable_bit];
    // Capture and reload split on the select bit, so a trigger never does both
    do_capture = hw_external_set & ~baud_mode
      & state_reg.control[timer2_pkg::capture_reload_select_bit];
    do_reload = (wrap & (baud_mode
      | ~state_reg.control[timer2_pkg::capture_reload_select_bit]))
      | (hw_external_set & ~baud_mode
      & ~state_reg.control[timer2_pkg::capture_reload_select_bit]);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wbyte = sfr_req.wdata;
    // Prescaler restarts when stopped so the first step is a full period
    if (!state_reg.control[timer2_pkg::run_control_bit] || step
      || state_reg.prescale >= divide - 4'h1)
    begin
      state_next.prescale = 4'h0;
    end
    else
    begin
      state_next.prescale = state_reg.prescale + 4'h1;
    end
    if (do_reload)
    begin
      state_next.count = state_reg.reload;
    end
    else if (step)
    begin
      state_next.count = state_reg.count + 16'h0001;
    end
    if (do_capture)
    begin
      state_next.reload = state_reg.count;
    end
    // Software writes; hardware flag sets below still win over a clear
    if (sfr_req.wr)
    begin
      unique case (sfr_req.addr)
        timer2_pkg::timer_control_off:
        begin
          state_next.control = wbyte;
        end
        timer2_pkg::timer_output_mode_off:
        begin
          state_next.ovf_out_enable = wbyte[timer2_pkg::ovf_out_enable_bit];
        end
        timer2_pkg::reload_low_off:
        begin
          state_next.reload[7:0] = wbyte;
        end
        timer2_pkg::reload_high_off:
        begin
          state_next.reload[15:8] = wbyte;
        end
        timer2_pkg::count_low_off:
        begin
          state_next.count[7:0] = wbyte;
        end
        timer2_pkg::count_high_off:
        begin
          state_next.count[15:8] = wbyte;
        end
        timer2_pkg::clock_speed_off:
        begin
          state_next.speed_select = wbyte[timer2_pkg::speed_select_bit];
        end
        timer2_pkg::port_option_off:
        begin
          state_next.pin_alt_output_enable = wbyte[timer2_pkg::pin_alt_output_enable_bit];
        end
        default:
        begin
          // Unmapped writes are dropped
        end
      endcase
    end
    if (hw_overflow_set)
    begin
      state_next.control[timer2_pkg::overflow_flag_bit] = 1'b1;
    end
    if (hw_external_set)
    begin
      state_next.control[timer2_pkg::external_flag_bit] = 1'b1;
    end
    if (sfr_req.rd)
    begin
      {state_next.hit, state_next.rdata} = read_decode(state_reg, sfr_req.addr);
    end
    else
    begin
      {state_next.hit, state_next.rdata} = 9'h000;
    end
    state_next.pin_out = wrap & state_reg.ovf_out_enable;
    // Enable needs both bits so the port keeps its other use until asked
    state_next.pin_oe = state_reg.ovf_out_enable & state_reg.pin_alt_output_enable;
    state_next.irq = state_next.control[timer2_pkg::overflow_flag_bit]
      | state_next.control[timer2_pkg::external_flag_bit];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= '{
        control: timer2_pkg::control_reset,
        ovf_out_enable: 1'b0,
        speed_select: 1'b0,
        pin_alt_output_enable: 1'b0,
        count: timer2_pkg::word_reset,
        reload: timer2_pkg::word_reset,
        prescale: 4'h0,
        rdata: timer2_pkg::byte_reset,
        hit: 1'b0,
        pin_out: 1'b0,
        pin_oe: 1'b0,
        irq: 1'b0
      };
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sfr_rdata = state_reg.rdata;
  assign sfr_hit = state_reg.hit;
  assign shared_port_pin_out = state_reg.pin_out;
  assign shared_port_pin_oe = state_reg.pin_oe;
  assign tx_bit_clock = tx_tick;
  assign rx_bit_clock = rx_tick;
  assign timer_irq_request = state_reg.irq;
endmodule // timer2_capture_reload_baudgen

// File: tb/far_pins.sv
// Far side model: pulled-up trigger and count lines, bit clock gap meter.
// Assumes requests are one clk wide and spaced by more than 12 clocks.
`timescale 1ns/10ps
module far_pins (
  input wire logic clk,
  input wire logic trig_req,
  input wire logic count_req,
  input wire logic tx_bit_clock,
  output logic trigger_pin,
  output logic count_pin,
  output logic [15:0] tx_gap
);
  logic [2:0] trig_low = 3'h0;
  logic [2:0] cnt_low = 3'h0;
  logic [15:0] since = 16'h0000;
  // Held low six clocks so a three-flop synchroniser cannot miss it
  assign trigger_pin = (trig_low == 3'h0);
  assign count_pin = (cnt_low == 3'h0);
  always @(posedge clk)
  begin
    trig_low <= trig_req ? 3'h6 : trig_low - {2'h0, trig_low != 3'h0};
    cnt_low <= count_req ? 3'h6 : cnt_low - {2'h0, cnt_low != 3'h0};
    since <= tx_bit_clock ? 16'h0000 : since + 16'h0001;
    if (tx_bit_clock)
      tx_gap <= since + 16'h0001;
  end
endmodule // far_pins

// File: tb/timer2_asserts.sv
// Port checker for the timer, bound to the top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module timer2_asserts (
  input wire logic clk,
  input wire logic reset,
  input timer2_pkg::sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic trigger_pin,
  input wire logic count_pin,
  input wire logic shared_port_pin_out,
  input wire logic shared_port_pin_oe,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic timer_irq_request
);
  logic mapped;
  logic ctl_wr;
  assign mapped = sfr_req.addr inside {8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h8e, 8'hd0};
  assign ctl_wr = sfr_req.wr && sfr_req.addr == 8'hc8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_pulse_width:
    assert property (shared_port_pin_out |=> !shared_port_pin_out) else $error("pulse too wide");
  chk_rdata_idle:
    assert property (!sfr_req.rd |=> sfr_rdata == 8'h00) else $error("stray read data");
  chk_unmapped_read:
    assert property (sfr_req.rd && !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  chk_mapped_hit:
    assert property (sfr_req.rd && mapped |=> sfr_hit) else $error("mapped read missed");
  chk_flag_hold:
    assert property (timer_irq_request && !ctl_wr && !$past(ctl_wr) |=> timer_irq_request)
    else $error("flag dropped without a write");
  chk_tx_spacing:
    assert property (tx_bit_clock |=> !tx_bit_clock [*8]) else $error("tx clock too fast");
  chk_rx_spacing:
    assert property (rx_bit_clock |=> !rx_bit_clock [*8]) else $error("rx clock too fast");
  chk_oe_by_write:
    assert property ($changed(shared_port_pin_oe) |-> $past(sfr_req.wr) || $past(sfr_req.wr, 2))
    else $error("pin enable moved alone");
  chk_quiet_reset:
    assert property ($fell(reset) |-> !timer_irq_request && !shared_port_pin_oe && !tx_bit_clock)
    else $error("outputs busy after reset");
endmodule // timer2_asserts

bind timer2_capture_reload_baudgen timer2_asserts chk_u (.clk(clk), .reset(reset),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .trigger_pin(trigger_pin),
  .count_pin(count_pin), .shared_port_pin_out(shared_port_pin_out),
  .shared_port_pin_oe(shared_port_pin_oe), .tx_bit_clock(tx_bit_clock),
  .rx_bit_clock(rx_bit_clock), .timer_irq_request(timer_irq_request));

// File: tb/tb_top.sv
// Testbench: register tasks and one task per scenario.
// Assumes far_pins drives the trigger and count pins.
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  timer2_pkg::sfr_req_t req = '0;
  logic [1:0] pin_req = 2'h0;
  logic [7:0] rdata;
  logic hit, trig, cnt, pin_out, pin_oe, txc, rxc, irq;
  logic [15:0] tx_gap;
  int fail_count, total_checks, pulses, n, p0, rx_ticks, r0;
  timer2_capture_reload_baudgen dut_u (.clk(clk), .reset(reset), .sfr_req(req),
    .sfr_rdata(rdata), .sfr_hit(hit), .trigger_pin(trig), .count_pin(cnt),
    .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe), .tx_bit_clock(txc),
    .rx_bit_clock(rxc), .timer_irq_request(irq));
  far_pins far_u (.clk(clk), .trig_req(pin_req[0]), .count_req(pin_req[1]),
    .tx_bit_clock(txc), .trigger_pin(trig), .count_pin(cnt), .tx_gap(tx_gap));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (pin_out === 1'b1)
      pulses <= pulses + 1;
    if (rxc === 1'b1)
      rx_ticks <= rx_ticks + 1;
  end
  // ----------------------------------------
  // Bus, pin and compare tasks
  // ----------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= v;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task pulse(input int i);
    @(posedge clk);
    pin_req[i] <= 1'b1;
    @(posedge clk);
    pin_req[i] <= 1'b0;
    repeat (14) @(posedge clk);
  endtask
  task wait_pulse;
    n = 0;
    while (pin_out !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rchk(8'hc8, 8'h00);
    chk({15'h0, hit}, 16'h0001);
    rchk(8'h00, 8'h00);
    chk({15'h0, hit}, 16'h0000);
    wr(8'hc9, 8'hff);
    rchk(8'hc9, 8'h02);
    $display("t_regs done");
  endtask
  task t_plain;
    wr(8'hd0, 8'h01);
    wr(8'hcc, 8'hfd);
    wr(8'hcd, 8'hff);
    wr(8'h8e, 8'h20);
    wr(8'hc8, 8'h04);
    wait_pulse();
    chk({15'h0, n <= 16}, 16'h0001);
    chk({15'h0, pin_oe}, 16'h0001);
    rchk(8'hc8, 8'h84);
    chk({15'h0, irq}, 16'h0001);
    wr(8'hc8, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0000);
    wr(8'h8e, 8'h00);
    wr(8'hcc, 8'hfd);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    wait_pulse();
    chk({15'h0, n >= 24 && n < 400}, 16'h0001);
    $display("t_plain done");
  endtask
  task t_reload;
    wr(8'hc8, 8'h00);
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    wait_pulse();
    chk({15'h0, n == 24}, 16'h0001);
    wr(8'hc8, 8'h00);
    rchk(8'hcc, 8'hfe);
    rchk(8'hcd, 8'hff);
    repeat (30) @(posedge clk);
    rchk(8'hcc, 8'hfe);
    $display("t_reload done");
  endtask
  task t_trigger;
    wr(8'hcc, 8'h34);
    wr(8'hcd, 8'h12);
    wr(8'hc8, 8'h09);
    pulse(0);
    rchk(8'hca, 8'h34);
    rchk(8'hcb, 8'h12);
    rchk(8'hc8, 8'h49);
    chk({15'h0, irq}, 16'h0001);
    wr(8'hc8, 8'h08);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    pulse(0);
    rchk(8'hcc, 8'h34);
    rchk(8'hcd, 8'h12);
    rchk(8'hc8, 8'h48);
    wr(8'hc8, 8'h01);
    pulse(0);
    rchk(8'hc8, 8'h01);
    rchk(8'hca, 8'h34);
    $display("t_trigger done");
  endtask
  task t_count;
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h06);
    repeat (3) pulse(1);
    rchk(8'hcc, 8'h03);
    $display("t_count done");
  endtask
  task t_baud;
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h00);
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    p0 = pulses;
    r0 = rx_ticks;
    wr(8'hc8, 8'h3d);
    repeat (300) @(posedge clk);
    // Gap is 32 times 65536 less the reload value, so 64 clocks
    chk(tx_gap, 16'h0040);
    chk(16'(pulses - p0), 16'h0000);
    // 300 clocks hold four whole 64-clock receive periods
    chk(16'(rx_ticks - r0), 16'h0004);
    chk({15'h0, pin_oe}, 16'h0000);
    rchk(8'hc8, 8'h3d);
    pulse(0);
    rchk(8'hc8, 8'h7d);
    rchk(8'hca, 8'hfe);
    wr(8'hc8, 8'h00);
    $display("t_baud done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_plain();
    t_reload();
    t_trigger();
    t_count();
    t_baud();
    final_report();
  end
  // Tests need well under a thousand clocks; the 20000-clock limit leaves wide margin
  initial
  begin
    #800000;
    fail_count++;
    final_report();
  end
endmodule // tb_top
